/* File: design/debug_release.sv */
// Test port logic for debug entry, emulation enable and new program release
`timescale 1ns/1ps
`default_nettype none
`include "dbg_defs.svh"

// Overview of operation
// - Write command then opcode loads instruction latch
// - New_program_jump command then 16-bit address to data latch
// - Address write leaves debug, core jumps there
// - Debug-request instruction forces debug mode entry
// - Debug-request code shifted in, status shifted out
// - Capture-IR loads current core status bits
// - Update-IR of debug-request raises stop request
// - Status bits both one signal debug mode
// - Emulator-enable code shifted in, status out
// - Update-IR of enable opens command register
// - 8-bit commands shifted, executed on Update-DR
module debug_release #(
  parameter int LATCH_W = `DBG_LATCH_W,
  parameter int ADDR_W  = `DBG_ADDR_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     tck,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  input  wire logic [`DBG_STATUS_W-1:0] core_state_bits,
  output logic                          tdo,
  output logic                          tdo_oe_n,
  output logic                          debug_request,
  output logic                          emulator_enabled,
  output logic [LATCH_W-1:0]            instruction_latch,
  output logic [ADDR_W-1:0]             program_data_latch,
  output logic                          new_program_jump,
  output logic                          leave_debug_flag
);

  generate
    if (LATCH_W != `DBG_LATCH_W || ADDR_W > LATCH_W || ADDR_W < 1) begin : g_bad_width
      $error("debug_release: unsupported latch or address width");
    end
  endgenerate

  // Pin synchronisers
  logic [1:0] tck_sync_r;
  logic [1:0] tms_sync_r;
  logic [1:0] tdi_sync_r;
  logic       tck_prev_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tck_sync_r <= 2'h0;
      tms_sync_r <= 2'h3;
      tdi_sync_r <= 2'h3;
      tck_prev_r <= 1'b0;
    end else begin
      tck_sync_r <= {tck_sync_r[0], tck};
      tms_sync_r <= {tms_sync_r[0], tms};
      tdi_sync_r <= {tdi_sync_r[0], tdi};
      tck_prev_r <= tck_sync_r[1];
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;

  assign tck_s    = tck_sync_r[1];
  assign tms_s    = tms_sync_r[1];
  assign tdi_s    = tdi_sync_r[1];
  assign tck_rise = tck_s & ~tck_prev_r;
  assign tck_fall = ~tck_s & tck_prev_r;

  function automatic dbg_pkg::tap_state_e tap_next(input dbg_pkg::tap_state_e s,
                                                   input logic m);
    unique case (s)
      dbg_pkg::TLR:    tap_next = m ? dbg_pkg::TLR    : dbg_pkg::RTI;
      dbg_pkg::RTI:    tap_next = m ? dbg_pkg::SEL_DR : dbg_pkg::RTI;
      dbg_pkg::SEL_DR: tap_next = m ? dbg_pkg::SEL_IR : dbg_pkg::CAP_DR;
      dbg_pkg::CAP_DR: tap_next = m ? dbg_pkg::EX1_DR : dbg_pkg::SH_DR;
      dbg_pkg::SH_DR:  tap_next = m ? dbg_pkg::EX1_DR : dbg_pkg::SH_DR;
      dbg_pkg::EX1_DR: tap_next = m ? dbg_pkg::UPD_DR : dbg_pkg::PAU_DR;
      dbg_pkg::PAU_DR: tap_next = m ? dbg_pkg::EX2_DR : dbg_pkg::PAU_DR;
      dbg_pkg::EX2_DR: tap_next = m ? dbg_pkg::UPD_DR : dbg_pkg::SH_DR;
      dbg_pkg::UPD_DR: tap_next = m ? dbg_pkg::SEL_DR : dbg_pkg::RTI;
      dbg_pkg::SEL_IR: tap_next = m ? dbg_pkg::TLR    : dbg_pkg::CAP_IR;
      dbg_pkg::CAP_IR: tap_next = m ? dbg_pkg::EX1_IR : dbg_pkg::SH_IR;
      dbg_pkg::SH_IR:  tap_next = m ? dbg_pkg::EX1_IR : dbg_pkg::SH_IR;
      dbg_pkg::EX1_IR: tap_next = m ? dbg_pkg::UPD_IR : dbg_pkg::PAU_IR;
      dbg_pkg::PAU_IR: tap_next = m ? dbg_pkg::EX2_IR : dbg_pkg::PAU_IR;
      dbg_pkg::EX2_IR: tap_next = m ? dbg_pkg::UPD_IR : dbg_pkg::SH_IR;
      dbg_pkg::UPD_IR: tap_next = m ? dbg_pkg::SEL_DR : dbg_pkg::RTI;
    endcase
  endfunction

  dbg_pkg::tap_state_e     tap_r,     tap_nxt;
  dbg_pkg::dr_phase_e      phase_r,   phase_nxt;
  logic [`DBG_IR_W-1:0]    ir_sh_r,   ir_sh_nxt;
  logic [LATCH_W-1:0]      dr_sh_r,   dr_sh_nxt;
  logic                    bypass_r,  bypass_nxt;
  logic                    tdo_r,     tdo_nxt;
  logic                    oe_n_r,    oe_n_nxt;
  logic                    dbg_req_r, dbg_req_nxt;
  logic                    emu_en_r,  emu_en_nxt;
  logic [LATCH_W-1:0]      latch_r,   latch_nxt;
  logic [ADDR_W-1:0]       pdl_r,     pdl_nxt;
  logic                    jump_r,    jump_nxt;

  always_comb begin
    tap_nxt     = tap_r;
    phase_nxt   = phase_r;
    ir_sh_nxt   = ir_sh_r;
    dr_sh_nxt   = dr_sh_r;
    bypass_nxt  = bypass_r;
    tdo_nxt     = tdo_r;
    oe_n_nxt    = oe_n_r;
    dbg_req_nxt = 1'b0;
    emu_en_nxt  = emu_en_r;
    latch_nxt   = latch_r;
    pdl_nxt     = pdl_r;
    jump_nxt    = 1'b0;
    if (tck_rise) begin
      tap_nxt = tap_next(tap_r, tms_s);
      unique case (tap_r)
        dbg_pkg::TLR: begin
          ir_sh_nxt  = `DBG_IR_RESET;
          emu_en_nxt = 1'b0;
          phase_nxt  = dbg_pkg::PH_CMD;
        end
        dbg_pkg::CAP_IR: begin
          ir_sh_nxt = {core_state_bits, `DBG_IR_PREAMBLE};
        end
        dbg_pkg::SH_IR: begin
          ir_sh_nxt = {tdi_s, ir_sh_r[`DBG_IR_W-1:1]};
        end
        dbg_pkg::UPD_IR: begin
          dbg_req_nxt = (ir_sh_r == `DBG_IR_DEBUG_REQ);
          emu_en_nxt  = (ir_sh_r == `DBG_IR_EMU_ENABLE);
          phase_nxt   = dbg_pkg::PH_CMD;
        end
        dbg_pkg::CAP_DR: begin
          bypass_nxt = 1'b0;
        end
        dbg_pkg::SH_DR: begin
          if (emu_en_r) begin
            dr_sh_nxt = {dr_sh_r[LATCH_W-2:0], tdi_s};
          end else begin
            bypass_nxt = tdi_s;
          end
        end
        dbg_pkg::UPD_DR: begin
          if (emu_en_r) begin
            unique case (phase_r)
              dbg_pkg::PH_CMD: begin
                case (dr_sh_r[`DBG_CMD_W-1:0])
                  `DBG_CMD_WR_LATCH: phase_nxt = dbg_pkg::PH_WR_LATCH;
                  `DBG_CMD_NEW_PROGRAM_JUMP:     phase_nxt = dbg_pkg::PH_NEW_PROGRAM_JUMP;
                  `DBG_CMD_RD_LATCH: begin
                    dr_sh_nxt = latch_r;
                    phase_nxt = dbg_pkg::PH_READ;
                  end
                  default: ;
                endcase
              end
              dbg_pkg::PH_WR_LATCH: begin
                latch_nxt = dr_sh_r;
                phase_nxt = dbg_pkg::PH_CMD;
              end
              dbg_pkg::PH_NEW_PROGRAM_JUMP: begin
                pdl_nxt   = dr_sh_r[ADDR_W-1:0];
                jump_nxt  = 1'b1;
                phase_nxt = dbg_pkg::PH_CMD;
              end
              dbg_pkg::PH_READ: begin
                phase_nxt = dbg_pkg::PH_CMD;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
    if (tck_fall) begin
      oe_n_nxt = !(tap_r == dbg_pkg::SH_IR || tap_r == dbg_pkg::SH_DR);
      if (tap_r == dbg_pkg::SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (tap_r == dbg_pkg::SH_DR) begin
        tdo_nxt = emu_en_r ? dr_sh_r[LATCH_W-1] : bypass_r;
      end else begin
        tdo_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tap_r     <= dbg_pkg::TLR;
      phase_r   <= dbg_pkg::PH_CMD;
      ir_sh_r   <= `DBG_IR_RESET;
      dr_sh_r   <= `DBG_LATCH_RESET;
      bypass_r  <= 1'b0;
      tdo_r     <= 1'b0;
      oe_n_r    <= 1'b1;
      dbg_req_r <= 1'b0;
      emu_en_r  <= 1'b0;
      latch_r   <= `DBG_LATCH_RESET;
      pdl_r     <= ADDR_W'(`DBG_ADDR_RESET);
      jump_r    <= 1'b0;
    end else begin
      tap_r     <= tap_nxt;
      phase_r   <= phase_nxt;
      ir_sh_r   <= ir_sh_nxt;
      dr_sh_r   <= dr_sh_nxt;
      bypass_r  <= bypass_nxt;
      tdo_r     <= tdo_nxt;
      oe_n_r    <= oe_n_nxt;
      dbg_req_r <= dbg_req_nxt;
      emu_en_r  <= emu_en_nxt;
      latch_r   <= latch_nxt;
      pdl_r     <= pdl_nxt;
      jump_r    <= jump_nxt;
    end
  end

  assign tdo                = tdo_r;
  assign tdo_oe_n           = oe_n_r;
  assign debug_request      = dbg_req_r;
  assign emulator_enabled   = emu_en_r;
  assign instruction_latch  = latch_r;
  assign program_data_latch = pdl_r;
  assign new_program_jump   = jump_r;
  assign leave_debug_flag   = jump_r;

endmodule
`default_nettype wire

/* File: design/dbg_defs.svh */
// Constants for the debug entry and program release block
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

`define DBG_IR_W              4
`define DBG_IR_DEBUG_REQ      4'h7
`define DBG_IR_EMU_ENABLE     4'h6
`define DBG_IR_RESET          4'hf
`define DBG_IR_PREAMBLE       2'h1
`define DBG_STATUS_W          2
`define DBG_CMD_W             8
`define DBG_CMD_WR_LATCH      8'h09
`define DBG_CMD_NEW_PROGRAM_JUMP          8'h6c
`define DBG_CMD_RD_LATCH      8'h8b
`define DBG_LATCH_W           24
`define DBG_ADDR_W            16
`define DBG_JUMP_OPCODE       24'h0af080
`define DBG_LATCH_RESET       24'h000000
`define DBG_ADDR_RESET        16'h0000

`endif

/* File: design/dbg_pkg.sv */
// Types for the debug entry and program release block
`default_nettype none
package dbg_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    PH_CMD, PH_WR_LATCH, PH_NEW_PROGRAM_JUMP, PH_READ
  } dr_phase_e;

endpackage
`default_nettype wire

/* File: sim/debug_release_chk.sv */
// Port checker for the debug release block
`timescale 1ns/1ps
`default_nettype none
module debug_release_chk #(
  parameter int LATCH_W = 24,
  parameter int ADDR_W  = 16
) (
  input wire logic               clk_sys,
  input wire logic               arst_n,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdi,
  input wire logic [1:0]         core_state_bits,
  input wire logic               tdo,
  input wire logic               tdo_oe_n,
  input wire logic               debug_request,
  input wire logic               emulator_enabled,
  input wire logic [LATCH_W-1:0] instruction_latch,
  input wire logic [ADDR_W-1:0]  program_data_latch,
  input wire logic               new_program_jump,
  input wire logic               leave_debug_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_pair; new_program_jump == leave_debug_flag; endproperty
  a_pair: assert property (p_pair) else $error("jump and leave differ");
  property p_jump1; new_program_jump |=> !new_program_jump; endproperty
  a_jump1: assert property (p_jump1) else $error("jump pulse too long");
  property p_dreq1; debug_request |=> !debug_request; endproperty
  a_dreq1: assert property (p_dreq1) else $error("request pulse too long");
  property p_addr; !$stable(program_data_latch) |-> new_program_jump; endproperty
  a_addr: assert property (p_addr) else $error("address moved without jump");
  property p_latch; !$stable(instruction_latch) |-> emulator_enabled; endproperty
  a_latch: assert property (p_latch) else $error("latch written while disabled");
  property p_jump_en; new_program_jump |-> emulator_enabled; endproperty
  a_jump_en: assert property (p_jump_en) else $error("jump while disabled");
  property p_idle; debug_request |-> !emulator_enabled && !new_program_jump; endproperty
  a_idle: assert property (p_idle) else $error("emulation busy on request");
  property p_tdo; !$stable(tdo) |=> $stable(tdo)[*2] ##0 !(tdo_oe_n && tdo); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo unsettled or driven idle");
endmodule
bind debug_release debug_release_chk #(.LATCH_W(LATCH_W), .ADDR_W(ADDR_W)) debug_release_chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
  .core_state_bits(core_state_bits), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .debug_request(debug_request), .emulator_enabled(emulator_enabled),
  .instruction_latch(instruction_latch), .program_data_latch(program_data_latch),
  .new_program_jump(new_program_jump), .leave_debug_flag(leave_debug_flag));
`default_nettype wire

/* File: sim/jtag_ctrl_model.sv */
// Behavioural test port controller
`timescale 1ns/1ps
`default_nettype none
module jtag_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Pins set in low phase, tdo taken before rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #160;
    o = tdo;
    tck = 1'b1;
    #160;
    tck = 1'b0;
  endtask
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [23:0] din,
                      output logic [23:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, ir ? din[i] : din[n - 1 - i], o);
      if (ir) dout[i] = o;
      else dout[n - 1 - i] = o;
    end
    step(1'b1, ~tdi, o);
    repeat (2) step(1'b0, ~tdi, o);
  endtask
endmodule
`default_nettype wire

/* File: sim/debug_release_test.sv */
// Testbench for the debug release block
`timescale 1ns/1ps
`default_nettype none
module debug_release_test;
  logic        clk_sys, arst_n, tck, tms, tdi, tdo, tdo_oe_n, debug_request;
  logic        emulator_enabled, new_program_jump, leave_debug_flag;
  logic [1:0]  core_state_bits;
  logic [23:0] instruction_latch, dout;
  logic [15:0] program_data_latch;
  int          error_cnt, n_checks, dreq_cnt, jump_cnt;
  // Status in, captured pattern out
  logic [5:0]  rows [4] = '{6'h01, 6'h15, 6'h29, 6'h3d};
  debug_release debug_release_i (.clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .core_state_bits(core_state_bits), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .debug_request(debug_request), .emulator_enabled(emulator_enabled),
    .instruction_latch(instruction_latch), .program_data_latch(program_data_latch),
    .new_program_jump(new_program_jump), .leave_debug_flag(leave_debug_flag));
  jtag_ctrl_model jtag_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (debug_request === 1'b1) dreq_cnt++;
    if (new_program_jump === 1'b1 && leave_debug_flag === 1'b1) jump_cnt++;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    core_state_bits = 2'h0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(48'({instruction_latch, program_data_latch, emulator_enabled, tdo_oe_n}), 48'h1);
    jtag_ctrl_model_i.tap_reset();
    for (int i = 0; i < 4; i++) begin
      core_state_bits = rows[i][5:4];
      jtag_ctrl_model_i.scan(1'b1, 4, 24'h7, dout);
      chk(48'(dout[3:0]), 48'(rows[i][3:0]));
      chk(48'(dreq_cnt), 48'(i + 1));
    end
    jtag_ctrl_model_i.scan(1'b1, 4, 24'h6, dout);
    chk(48'({dout[3:0], emulator_enabled}), 48'h1b);
    chk(48'(dreq_cnt), 48'h4);
    jtag_ctrl_model_i.scan(1'b0, 8, 24'h09, dout);
    jtag_ctrl_model_i.scan(1'b0, 24, 24'h0af080, dout);
    chk(48'(instruction_latch), 48'h0af080);
    jtag_ctrl_model_i.scan(1'b0, 8, 24'h8b, dout);
    jtag_ctrl_model_i.scan(1'b0, 24, 24'h0, dout);
    chk(48'(dout), 48'h0af080);
    jtag_ctrl_model_i.scan(1'b0, 8, 24'h6c, dout);
    jtag_ctrl_model_i.scan(1'b0, 16, 24'ha5c3, dout);
    chk(48'({program_data_latch, 8'(jump_cnt)}), 48'ha5c301);
    // Disabled emulation ignores a new_program_jump
    jtag_ctrl_model_i.tap_reset();
    chk(48'(emulator_enabled), 48'h0);
    jtag_ctrl_model_i.scan(1'b0, 8, 24'h6c, dout);
    jtag_ctrl_model_i.scan(1'b0, 16, 24'h1111, dout);
    chk(48'(dout), 48'h000888);
    chk(48'({program_data_latch, 8'(jump_cnt)}), 48'ha5c301);
    // Device reset clears both latches
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(48'({instruction_latch, program_data_latch}), 48'h0);
    end_sim();
  end
endmodule
`default_nettype wire
